// ---- common/rtcia_pkg.sv ----
// package of constants for the rtc serial target
package rtcia_pkg;
  localparam logic [6:0] DEV_ADDR = 7'h6f;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] PTR_LAST = 8'h13;
  localparam logic [7:0] PTR_FIRST = 8'h00;
  localparam int REG_COUNT = 20;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEV = 3'b001,
    ST_WORD = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100,
    ST_ACK = 3'b101,
    ST_MACK = 3'b110,
    ST_IGNORE = 3'b111
  } rtcia_state_type;
endpackage

// ---- design/rtcia_regmem.sv ----
// register array memory with registered read data
`timescale 1ns/10ps
module rtcia_regmem (
  // clock
  input wire logic clk,
  input wire logic ce,
  // write port
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  // read port
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [0:rtcia_pkg::REG_COUNT-1];
  always_ff @(posedge clk) begin
    if (ce) begin
      if (wr_en && wr_addr <= rtcia_pkg::PTR_LAST) begin
        mem[wr_addr[4:0]] <= wr_data;
      end
      if (rd_addr <= rtcia_pkg::PTR_LAST) begin
        rd_data <= mem[rd_addr[4:0]];
      end else begin
        rd_data <= 8'h00;
      end
    end
  end
endmodule

// ---- design/rtcia_target.sv ----
// two-wire serial target for the clock register array
// Function
// - acknowledge id, address, and third byte
// - after one data byte, ignore the bus awaiting start or stop
// - keep sending bytes while master acknowledges
// - pointer loads from address, increments per byte
// - pointer wraps from 13h to 00h
// - match seven id bits; lsb selects read
// - pointer clears to zero at reset
// - bytes shifted most significant bit first
`timescale 1ns/10ps
module rtcia_target (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // status
  output logic [7:0] ptr_out,
  output logic busy
);
  logic [1:0] scl_s_q, sda_s_q;
  logic scl_q, sda_q;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  rtcia_pkg::rtcia_state_type st_q, st_d, ret_q, ret_d;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d;
  logic [2:0] cnt_q, cnt_d;
  logic oe_q, oe_d, rd_q, rd_d, addr_ok_q, addr_ok_d, busy_q, busy_d;
  logic wr_en;
  logic [7:0] mem_rd;

  function automatic logic [7:0] next_ptr(input logic [7:0] p);
    next_ptr = (p == rtcia_pkg::PTR_LAST) ? rtcia_pkg::PTR_FIRST : p + 8'h01;
  endfunction

  always_ff @(posedge clk) begin
    if (reset) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (ce) begin
      scl_s_q <= {scl_s_q[0], scl_i};
      sda_s_q <= {sda_s_q[0], sda_i};
      scl_q <= scl_s_q[1];
      sda_q <= sda_s_q[1];
    end
  end
  assign scl_rise = scl_s_q[1] && !scl_q;
  assign scl_fall = !scl_s_q[1] && scl_q;
  assign start_cond = scl_s_q[1] && scl_q && sda_q && !sda_s_q[1];
  assign stop_cond = scl_s_q[1] && scl_q && !sda_q && sda_s_q[1];

  rtcia_regmem u_mem (
    .clk(clk),
    .ce(ce),
    .wr_en(wr_en),
    .wr_addr(ptr_q),
    .wr_data(sh_q),
    .rd_addr(ptr_q),
    .rd_data(mem_rd)
  );

  always_comb begin
    st_d = st_q;
    ret_d = ret_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    cnt_d = cnt_q;
    oe_d = oe_q;
    rd_d = rd_q;
    addr_ok_d = addr_ok_q;
    busy_d = busy_q;
    wr_en = 1'b0;
    if (start_cond) begin
      st_d = rtcia_pkg::ST_DEV;
      cnt_d = rtcia_pkg::BIT_FIRST;
      addr_ok_d = 1'b0;
      oe_d = 1'b0;
      busy_d = 1'b1;
    end else if (stop_cond) begin
      st_d = rtcia_pkg::ST_IDLE;
      addr_ok_d = 1'b0;
      oe_d = 1'b0;
      busy_d = 1'b0;
    end else begin
      unique case (st_q)
        rtcia_pkg::ST_IDLE, rtcia_pkg::ST_IGNORE: begin
          oe_d = 1'b0;
        end
        rtcia_pkg::ST_DEV, rtcia_pkg::ST_WORD, rtcia_pkg::ST_WDATA: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda_q};
            cnt_d = cnt_q + 3'h1;
          end
          if (scl_fall && addr_ok_q) begin
            addr_ok_d = 1'b0;
            unique case (st_q)
              rtcia_pkg::ST_DEV: begin
                if (sh_q[7:1] == rtcia_pkg::DEV_ADDR) begin
                  rd_d = sh_q[0];
                  oe_d = 1'b1;
                  st_d = rtcia_pkg::ST_ACK;
                  ret_d = sh_q[0] ? rtcia_pkg::ST_RDATA : rtcia_pkg::ST_WORD;
                end else begin
                  st_d = rtcia_pkg::ST_IGNORE;
                end
              end
              rtcia_pkg::ST_WORD: begin
                ptr_d = sh_q;
                oe_d = 1'b1;
                st_d = rtcia_pkg::ST_ACK;
                ret_d = rtcia_pkg::ST_WDATA;
              end
              default: begin
                wr_en = 1'b1;
                ptr_d = next_ptr(ptr_q);
                oe_d = 1'b1;
                st_d = rtcia_pkg::ST_ACK;
                ret_d = rtcia_pkg::ST_IGNORE;
              end
            endcase
          end else if (scl_rise && cnt_q == rtcia_pkg::BIT_LAST) begin
            addr_ok_d = 1'b1;
          end
        end
        rtcia_pkg::ST_ACK: begin
          if (scl_fall) begin
            cnt_d = rtcia_pkg::BIT_FIRST;
            st_d = ret_q;
            if (ret_q == rtcia_pkg::ST_RDATA) begin
              sh_d = mem_rd;
              ptr_d = next_ptr(ptr_q);
              oe_d = !mem_rd[7];
            end else begin
              oe_d = 1'b0;
            end
          end
        end
        rtcia_pkg::ST_RDATA: begin
          if (scl_fall) begin
            if (cnt_q == rtcia_pkg::BIT_LAST) begin
              oe_d = 1'b0;
              st_d = rtcia_pkg::ST_MACK;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              oe_d = !sh_q[6];
            end
            cnt_d = cnt_q + 3'h1;
          end
        end
        rtcia_pkg::ST_MACK: begin
          // master acknowledge is only recorded here, the line stays released
          if (scl_rise) begin
            addr_ok_d = !sda_q;
            if (sda_q) begin
              st_d = rtcia_pkg::ST_IGNORE;
            end
          end else if (scl_fall && addr_ok_q) begin
            addr_ok_d = 1'b0;
            cnt_d = rtcia_pkg::BIT_FIRST;
            st_d = rtcia_pkg::ST_RDATA;
            sh_d = mem_rd;
            ptr_d = next_ptr(ptr_q);
            oe_d = !mem_rd[7];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= rtcia_pkg::ST_IDLE;
      ret_q <= rtcia_pkg::ST_IDLE;
      sh_q <= 8'h00;
      ptr_q <= rtcia_pkg::PTR_RESET;
      cnt_q <= 3'h0;
      oe_q <= 1'b0;
      rd_q <= 1'b0;
      addr_ok_q <= 1'b0;
      busy_q <= 1'b0;
    end else if (ce) begin
      st_q <= st_d;
      ret_q <= ret_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      cnt_q <= cnt_d;
      oe_q <= oe_d;
      rd_q <= rd_d;
      addr_ok_q <= addr_ok_d;
      busy_q <= busy_d;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
      ptr_out <= 8'h00;
      busy <= 1'b0;
    end else if (ce) begin
      sda_o <= 1'b0;
      sda_oe <= oe_d;
      ptr_out <= ptr_d;
      busy <= busy_d;
    end
  end

  a_ptr_wrap: assert property (@(posedge clk) disable iff (reset)
    ce && scl_fall && ptr_q == rtcia_pkg::PTR_LAST &&
    (st_q == rtcia_pkg::ST_ACK && ret_q == rtcia_pkg::ST_RDATA ||
    st_q == rtcia_pkg::ST_MACK && addr_ok_q) |=> ptr_q == rtcia_pkg::PTR_FIRST)
    else $error("pointer did not wrap");
  a_ignore_quiet: assert property (@(posedge clk) disable iff (reset)
    st_q == rtcia_pkg::ST_IGNORE |=> !sda_oe)
    else $error("drive while ignoring");
  a_ptr_reset: assert property (@(posedge clk) $rose(!reset) |-> ptr_q == 8'h00)
    else $error("pointer not cleared");
  a_stop_idle: assert property (@(posedge clk) disable iff (reset)
    ce && stop_cond && !start_cond |=> st_q == rtcia_pkg::ST_IDLE && !busy)
    else $error("stop did not idle");
  a_ack_drive: assert property (@(posedge clk) disable iff (reset)
    ce && st_q == rtcia_pkg::ST_ACK && !start_cond && !stop_cond && !scl_fall |=> sda_oe)
    else $error("ack released early");
  a_nack_end: assert property (@(posedge clk) disable iff (reset)
    ce && st_q == rtcia_pkg::ST_MACK && scl_rise && sda_q && !start_cond && !stop_cond
    |=> st_q == rtcia_pkg::ST_IGNORE)
    else $error("nack did not end read");
  a_word_load: assert property (@(posedge clk) disable iff (reset)
    ce && st_q == rtcia_pkg::ST_WORD && st_d == rtcia_pkg::ST_ACK |=> ptr_q == $past(sh_q))
    else $error("pointer not loaded");
  a_foreign_quiet: assert property (@(posedge clk) disable iff (reset)
    ce && st_q == rtcia_pkg::ST_DEV && st_d == rtcia_pkg::ST_IGNORE |=> !sda_oe)
    else $error("acked wrong id");
  a_mack_release: assert property (@(posedge clk) disable iff (reset)
    st_q == rtcia_pkg::ST_MACK |-> !sda_oe)
    else $error("drive during master acknowledge");
  a_read_dir: assert property (@(posedge clk) disable iff (reset)
    st_q == rtcia_pkg::ST_RDATA |-> rd_q)
    else $error("read data without read id");
endmodule

// ---- dv/rtcia_master.sv ----
// two-wire bus master model for the rtc target bench
`timescale 1ns/10ps
module rtcia_master (
  // clock
  input wire logic clk,
  // bus
  input wire logic sda_line,
  output logic scl,
  output logic sda_m
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // hold both lines for n quarters of five clocks
  task automatic drv(input logic s, input logic d, input int n);
    scl = s;
    sda_m = d;
    repeat (n * 5) @(negedge clk);
  endtask
  // data only moves a quarter after clock falls
  task automatic low(input logic d);
    drv(1'b0, sda_m, 1);
    drv(1'b0, d, 1);
  endtask
  task automatic start();
    low(1'b1);
    drv(1'b1, 1'b1, 2);
    drv(1'b1, 1'b0, 2);
  endtask
  task automatic stop();
    low(1'b0);
    drv(1'b1, 1'b0, 2);
    drv(1'b1, 1'b1, 2);
  endtask
  task automatic bit_io(input logic d, output logic q);
    low(d);
    drv(1'b1, d, 2);
    q = sda_line;
  endtask
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ack_in, ack);
  endtask
endmodule

// ---- dv/rtcia_target_tb.sv ----
// self-checking bench for the rtc serial target
`timescale 1ns/10ps
module rtcia_target_tb;
  logic clk;
  logic reset;
  logic ce;
  logic scl;
  logic sda_m;
  logic sda_o;
  logic sda_oe;
  logic busy;
  logic [7:0] ptr_out;
  wire logic sda_line;
  int failures;
  int comparisons;
  // open drain with pull-up
  assign sda_line = sda_m & ~(sda_oe & ~sda_o);
  rtcia_target i_dut (.clk(clk), .reset(reset), .ce(ce), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .ptr_out(ptr_out), .busy(busy));
  rtcia_master i_mst (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_m(sda_m));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t ns: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic send(input logic [7:0] d, input logic exp_ack, input string msg);
    logic [7:0] q;
    logic a;
    i_mst.xfer(d, 1'b1, q, a);
    check({7'h00, a}, {7'h00, ~exp_ack}, msg);
  endtask
  task automatic write_byte(input logic [7:0] addr, input logic [7:0] data, input logic extra);
    i_mst.start();
    send({rtcia_pkg::DEV_ADDR, 1'b0}, 1'b1, "id ack");
    send(addr, 1'b1, "address ack");
    send(data, 1'b1, "data ack");
    if (extra) begin
      send(8'hff, 1'b0, "extra data nack");
    end
    i_mst.stop();
    check(ptr_out, (addr == rtcia_pkg::PTR_LAST) ? rtcia_pkg::PTR_FIRST : addr + 8'h01,
      "write pointer");
    check({7'h00, busy}, 8'h00, "idle after stop");
  endtask
  task automatic read_wrap();
    logic [7:0] q;
    logic a;
    i_mst.start();
    send({rtcia_pkg::DEV_ADDR, 1'b0}, 1'b1, "id ack");
    send(8'h12, 1'b1, "address ack");
    i_mst.start();
    send({rtcia_pkg::DEV_ADDR, 1'b1}, 1'b1, "read id ack");
    i_mst.xfer(8'hff, 1'b0, q, a);
    check(q, 8'ha5, "first byte");
    i_mst.xfer(8'hff, 1'b0, q, a);
    check(q, 8'h3c, "second byte");
    i_mst.xfer(8'hff, 1'b1, q, a);
    check(q, 8'h5a, "wrapped byte");
    i_mst.stop();
    check(ptr_out, 8'h01, "pointer after read");
  endtask
  task automatic wrong_id();
    i_mst.start();
    send({7'h6e, 1'b0}, 1'b0, "foreign id");
    send(8'h00, 1'b0, "ignored byte");
    i_mst.stop();
    check(ptr_out, 8'h01, "pointer kept");
  endtask
  task automatic freeze_reset_read();
    logic [7:0] q;
    logic a;
    ce = 1'b0;
    i_mst.start();
    check({7'h00, busy}, 8'h00, "start unseen while frozen");
    ce = 1'b1;
    repeat (4) @(negedge clk);
    check({7'h00, busy}, 8'h01, "start seen after thaw");
    i_mst.stop();
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    check(ptr_out, rtcia_pkg::PTR_RESET, "pointer after mid-run reset");
    repeat (4) @(negedge clk);
    i_mst.start();
    send({rtcia_pkg::DEV_ADDR, 1'b1}, 1'b1, "current read id ack");
    i_mst.xfer(8'hff, 1'b1, q, a);
    check(q, 8'h5a, "current address byte");
    i_mst.stop();
    check(ptr_out, 8'h01, "pointer after current read");
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    failures = 0;
    comparisons = 0;
    reset = 1'b1;
    ce = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    check(ptr_out, rtcia_pkg::PTR_RESET, "pointer at reset");
    check({6'h00, busy, sda_oe}, 8'h00, "bus idle at reset");
    repeat (4) @(negedge clk);
    write_byte(8'h00, 8'h5a, 1'b0);
    write_byte(8'h12, 8'ha5, 1'b0);
    write_byte(8'h13, 8'h3c, 1'b1);
    read_wrap();
    wrong_id();
    freeze_reset_read();
    complete_run();
  end
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    complete_run();
  end
endmodule
